// ---- core/cab_map.vh ----
`ifndef CAB_MAP_VH
`define CAB_MAP_VH
// Opcodes on the micro-instruction port
`define CAB_OP_NOP      4'h0
`define CAB_OP_WREG     4'h1
`define CAB_OP_RREG     4'h2
`define CAB_OP_WAUX     4'h3
`define CAB_OP_RAUX     4'h4
`define CAB_OP_ADD      4'h5
`define CAB_OP_SUB      4'h6
`define CAB_OP_AND      4'h7
`define CAB_OP_SENSE    4'h8
`define CAB_OP_BZ       4'h9
`define CAB_OP_BNZ      4'hA
`define CAB_OP_BCY      4'hB
`define CAB_OP_JMP      4'hC
`define CAB_OP_BAL      4'hD
`define CAB_OP_RET      4'hE
`define CAB_OP_MEM      4'hF
// Long time-out control codes carried on the i_tmo_cmd port
`define CAB_TMO_ENABLE  2'h1
`define CAB_TMO_DISABLE 2'h2
`define CAB_TMO_RESET   2'h3
// Sense byte bit positions
`define CAB_SNS_ZERO    0
`define CAB_SNS_NZERO   1
`define CAB_SNS_CARRY   2
// Sizes and reset values
`define CAB_NREG        16
`define CAB_NAUX        16
`define CAB_NLEVEL      3
`define CAB_MEM_AW      14
`define CAB_MEM_HIBASE  14'h2000
`define CAB_ADDR_W      16
`define CAB_RST_BYTE    8'h00
`define CAB_RST_PC      16'h0000
`define CAB_RST_LEVEL   2'h0
// Long time-out counter values
`define CAB_TMO_CLEAR   16'h0000
`define CAB_TMO_STEP    16'h0001
`define CAB_TMO_LAST    16'h0001
`endif

// ---- core/cab_core.v ----
`timescale 1ns/1ps
// Overview of operation
// - Primary registers store and return written bytes
// - Primary registers hold patterns 5 and A
// - Auxiliary registers independently selectable by address
// - Auxiliary registers hold patterns 5 and A
// - Nonzero result sets nonzero, clears zero; carry takes bit 8
// - Zero result sets zero, clears nonzero; carry takes bit 8
// - Carry kept separately, readable by sense
// - Zero set: branch_if_zero and unconditional jump taken, others fall
// - Nonzero set: branch_if_nonzero and unconditional jump taken, others fall
// - Zero and carry: both those branches taken
// - Nonzero and carry: both those branches taken
// - Unconditional jump always taken
// - Branch-and-link returns to following instruction
// - Three nested levels keep separate returns
// - Whole controller memory writable and readable
// - Enabled loaded time-out interrupts host
// - Interrupt only when loaded time expires
// - Disable cancels the time-out interrupt
// - Reset time-out cancels pending expiry
`include "cab_map.vh"
module cab_core (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_op_valid,
    input  wire [3:0]  i_op_code,
    input  wire [3:0]  i_op_sel,
    input  wire [7:0]  i_op_data,
    input  wire [15:0] i_op_addr,
    input  wire        i_mem_we,
    input  wire        i_tmo_valid,
    input  wire [1:0]  i_tmo_cmd,
    input  wire [15:0] i_tmo_value,
    input  wire        i_int_ack,
    output reg  [7:0]  o_rd_data,
    output reg         o_rd_valid,
    output reg  [15:0] o_pc,
    output reg         o_taken,
    output reg  [1:0]  o_level,
    output reg         o_ind_zero,
    output reg         o_ind_nzero,
    output reg         o_ind_carry,
    output reg         o_int_req
);
    // Storage
    reg  [7:0]  reg_q  [0:`CAB_NREG-1];
    reg  [7:0]  aux_q  [0:`CAB_NAUX-1];
    // Memory is not reset: contents are undefined until written
    reg  [7:0]  mem_q  [0:(1<<`CAB_MEM_AW)-1];
    reg  [15:0] link_q [0:`CAB_NLEVEL-1];
    // Time-out state
    reg  [15:0] tmo_cnt_q;
    reg  [15:0] tmo_cnt_d;
    reg         tmo_run_q;
    reg         tmo_run_d;
    reg         int_req_d;
    // Next values of the registered outputs
    reg  [15:0] pc_d;
    reg         taken_d;
    reg  [1:0]  level_d;
    reg  [7:0]  rd_data_d;
    reg         rd_valid_d;
    reg  [2:0]  flags_d;
    // Datapath
    reg  [8:0]  alu_sum;
    reg         cond;
    wire [7:0]  opnd;
    wire [15:0] pc_inc;
    wire [`CAB_MEM_AW-1:0] mem_addr;
    wire        is_alu;
    wire        is_branch;
    wire        mem_wr;
    wire        link_room;
    wire        link_any;
    wire        tmo_load;
    wire        tmo_stop;
    integer     ki;
    integer     ka;
    integer     kl;

    // Indicator update shared by every condition-setting op
    function [2:0] cab_flags;
        input [8:0] res;
        begin
            cab_flags = {res[8], (res[7:0] != 8'h00), (res[7:0] == 8'h00)};
        end
    endfunction

    // Ops that set the indicators
    function cab_is_alu;
        input [3:0] code;
        begin
            cab_is_alu = (code == `CAB_OP_ADD) || (code == `CAB_OP_SUB) || (code == `CAB_OP_AND);
        end
    endfunction

    // Plain jumps only; link ops have their own path
    function cab_is_branch;
        input [3:0] code;
        begin
            cab_is_branch = (code == `CAB_OP_BZ) || (code == `CAB_OP_BNZ) ||
                            (code == `CAB_OP_BCY) || (code == `CAB_OP_JMP);
        end
    endfunction

    assign opnd      = reg_q[i_op_sel];
    assign pc_inc    = o_pc + 16'h0001;
    assign mem_addr  = i_op_addr[`CAB_MEM_AW-1:0];
    assign is_alu    = i_op_valid && cab_is_alu(i_op_code);
    assign is_branch = i_op_valid && cab_is_branch(i_op_code);
    assign mem_wr    = i_op_valid && (i_op_code == `CAB_OP_MEM) && i_mem_we;
    // A fourth nested call is ignored rather than corrupting a link
    assign link_room = (o_level < `CAB_NLEVEL);
    assign link_any  = (o_level != `CAB_RST_LEVEL);
    assign tmo_load  = i_tmo_valid && (i_tmo_cmd == `CAB_TMO_ENABLE);
    assign tmo_stop  = i_tmo_valid && ((i_tmo_cmd == `CAB_TMO_DISABLE) || (i_tmo_cmd == `CAB_TMO_RESET));

    always @* begin
        alu_sum = 9'h000;
        case (i_op_code)
            `CAB_OP_ADD: alu_sum = {1'b0, opnd} + {1'b0, i_op_data};
            `CAB_OP_SUB: alu_sum = {1'b0, opnd} + {1'b0, ~i_op_data} + 9'h001;
            `CAB_OP_AND: alu_sum = {1'b0, opnd & i_op_data};
            default:     alu_sum = 9'h000;
        endcase
    end

    always @* begin
        cond = 1'b0;
        case (i_op_code)
            `CAB_OP_BZ:  cond = o_ind_zero;
            `CAB_OP_BNZ: cond = o_ind_nzero;
            `CAB_OP_BCY: cond = o_ind_carry;
            `CAB_OP_JMP: cond = 1'b1;
            default:     cond = 1'b0;
        endcase
    end

    // Sequencing: every accepted op advances the counter unless it jumps
    always @* begin
        pc_d    = o_pc;
        taken_d = 1'b0;
        level_d = o_level;
        if (i_op_valid) begin
            pc_d = pc_inc;
            if (is_branch && cond) begin
                pc_d    = i_op_addr;
                taken_d = 1'b1;
            end else if ((i_op_code == `CAB_OP_BAL) && link_room) begin
                pc_d    = i_op_addr;
                taken_d = 1'b1;
                level_d = o_level + 2'h1;
            end else if ((i_op_code == `CAB_OP_RET) && link_any) begin
                pc_d    = link_q[o_level - 2'h1];
                taken_d = 1'b1;
                level_d = o_level - 2'h1;
            end
        end
    end

    // Read port; data holds until the next read
    always @* begin
        rd_data_d  = o_rd_data;
        rd_valid_d = 1'b0;
        if (i_op_valid) begin
            case (i_op_code)
                `CAB_OP_RREG: begin
                    rd_data_d  = reg_q[i_op_sel];
                    rd_valid_d = 1'b1;
                end
                `CAB_OP_RAUX: begin
                    rd_data_d  = aux_q[i_op_sel];
                    rd_valid_d = 1'b1;
                end
                `CAB_OP_SENSE: begin
                    rd_data_d  = {5'h00, o_ind_carry, o_ind_nzero, o_ind_zero};
                    rd_valid_d = 1'b1;
                end
                `CAB_OP_MEM: begin
                    if (!i_mem_we) begin
                        rd_data_d  = mem_q[mem_addr];
                        rd_valid_d = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Carry bit separate from zero and nonzero
    always @* begin
        flags_d = {o_ind_carry, o_ind_nzero, o_ind_zero};
        if (is_alu) begin
            flags_d = cab_flags(alu_sum);
        end
    end

    // Ack clears, but an expiry in the same cycle wins
    always @* begin
        tmo_cnt_d = tmo_cnt_q;
        tmo_run_d = tmo_run_q;
        int_req_d = o_int_req;
        if (i_int_ack) begin
            int_req_d = 1'b0;
        end
        if (tmo_load) begin
            // Reload while running restarts the full delay
            tmo_cnt_d = i_tmo_value;
            tmo_run_d = (i_tmo_value != `CAB_TMO_CLEAR);
        end else if (tmo_stop) begin
            tmo_cnt_d = `CAB_TMO_CLEAR;
            tmo_run_d = 1'b0;
        end else if (tmo_run_q) begin
            tmo_cnt_d = tmo_cnt_q - `CAB_TMO_STEP;
            if (tmo_cnt_q == `CAB_TMO_LAST) begin
                tmo_run_d = 1'b0;
                int_req_d = 1'b1;
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (mem_wr) begin
            mem_q[mem_addr] <= i_op_data;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (ki = 0; ki < `CAB_NREG; ki = ki + 1) begin
                reg_q[ki] <= `CAB_RST_BYTE;
            end
        end else if (i_op_valid && (i_op_code == `CAB_OP_WREG)) begin
            reg_q[i_op_sel] <= i_op_data;
        end else if (is_alu) begin
            reg_q[i_op_sel] <= alu_sum[7:0];
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (ka = 0; ka < `CAB_NAUX; ka = ka + 1) begin
                aux_q[ka] <= `CAB_RST_BYTE;
            end
        end else if (i_op_valid && (i_op_code == `CAB_OP_WAUX)) begin
            aux_q[i_op_sel] <= i_op_data;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            for (kl = 0; kl < `CAB_NLEVEL; kl = kl + 1) begin
                link_q[kl] <= `CAB_RST_PC;
            end
        end else if (i_op_valid && (i_op_code == `CAB_OP_BAL) && link_room) begin
            link_q[o_level] <= pc_inc;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_pc    <= `CAB_RST_PC;
            o_taken <= 1'b0;
            o_level <= `CAB_RST_LEVEL;
        end else begin
            o_pc    <= pc_d;
            o_taken <= taken_d;
            o_level <= level_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rd_data  <= `CAB_RST_BYTE;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_data  <= rd_data_d;
            o_rd_valid <= rd_valid_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_ind_zero  <= 1'b0;
            o_ind_nzero <= 1'b0;
            o_ind_carry <= 1'b0;
        end else begin
            o_ind_zero  <= flags_d[`CAB_SNS_ZERO];
            o_ind_nzero <= flags_d[`CAB_SNS_NZERO];
            o_ind_carry <= flags_d[`CAB_SNS_CARRY];
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            tmo_cnt_q <= `CAB_TMO_CLEAR;
            tmo_run_q <= 1'b0;
            o_int_req <= 1'b0;
        end else begin
            tmo_cnt_q <= tmo_cnt_d;
            tmo_run_q <= tmo_run_d;
            o_int_req <= int_req_d;
        end
    end
endmodule

// ---- dv/cab_host.sv ----
`timescale 1ns/1ps
module cab_host (
    input  wire       i_ref_clk,
    input  wire       i_int_req,
    input  wire [3:0] i_delay,
    output reg        o_int_ack
);
    reg [3:0] wait_q = 4'h0;
    initial o_int_ack = 1'b0;
    // Slow service widens the window where the request must stand
    always @(posedge i_ref_clk) begin
        o_int_ack <= 1'b0;
        wait_q    <= 4'h0;
        if (i_int_req && !o_int_ack) begin
            if (wait_q == i_delay)
                o_int_ack <= 1'b1;
            else
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ---- dv/cab_core_assertions.sv ----
`timescale 1ns/1ps
`include "cab_map.vh"
module cab_chk (
    input wire        i_ref_clk,
    input wire        i_rst_n,
    input wire        i_op_valid,
    input wire [3:0]  i_op_code,
    input wire [15:0] i_op_addr,
    input wire        i_tmo_valid,
    input wire [1:0]  i_tmo_cmd,
    input wire [15:0] i_tmo_value,
    input wire [15:0] o_pc,
    input wire        o_taken,
    input wire [1:0]  o_level,
    input wire        o_ind_zero,
    input wire        o_ind_nzero,
    input wire        o_ind_carry,
    input wire        o_int_req
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire [4:0] op = {i_op_valid, i_op_code};
    jump_hit_a: assert property (op == {1'b1, `CAB_OP_JMP} |=> o_taken && o_pc == $past(i_op_addr))
        else $error("jump missed");
    zero_br_a: assert property (op == {1'b1, `CAB_OP_BZ} |=> o_taken == $past(o_ind_zero))
        else $error("zero branch wrong");
    nzero_br_a: assert property (op == {1'b1, `CAB_OP_BNZ} |=> o_taken == $past(o_ind_nzero))
        else $error("nonzero branch wrong");
    carry_br_a: assert property (op == {1'b1, `CAB_OP_BCY} |=> o_taken == $past(o_ind_carry))
        else $error("carry branch wrong");
    flag_hold_a: assert property (!(op inside {5'h15, 5'h16, 5'h17})
        |=> $stable({o_ind_zero, o_ind_nzero, o_ind_carry})) else $error("flags moved");
    link_up_a: assert property (op == {1'b1, `CAB_OP_BAL} && o_level != 2'h3
        |=> o_level == $past(o_level) + 2'h1) else $error("link depth wrong");
    tmo_quiet_a: assert property (i_tmo_valid && i_tmo_cmd[1] && !o_int_req
        |=> ##1 !o_int_req [*4]) else $error("cancelled timer fired");
    tmo_early_a: assert property (i_tmo_valid && i_tmo_cmd == `CAB_TMO_ENABLE && i_tmo_value > 16'h0008
        && !o_int_req |=> !o_int_req [*8]) else $error("timer fired early");
endmodule
bind cab_core cab_chk i_cab_chk (.*);

// ---- dv/controller_alu_branch_timeout_tb.sv ----
`timescale 1ns/1ps
`include "cab_map.vh"
module controller_alu_branch_timeout_tb;
    reg         i_ref_clk = 1'b0, i_rst_n = 1'b0, i_op_valid = 1'b0, i_mem_we = 1'b0, i_tmo_valid = 1'b0;
    reg  [3:0]  i_op_code = 4'h0, i_op_sel = 4'h0, host_dly = 4'h0;
    reg  [7:0]  i_op_data = 8'h00;
    reg  [15:0] i_op_addr = 16'h0000, i_tmo_value = 16'h0000;
    reg  [1:0]  i_tmo_cmd = 2'h0;
    wire        i_int_ack, o_rd_valid, o_taken, o_ind_zero, o_ind_nzero, o_ind_carry, o_int_req;
    wire [7:0]  o_rd_data;
    wire [15:0] o_pc;
    wire [1:0]  o_level;
    integer     bad_count = 0, n_tests = 0, cyc = 0, i, k, n;
    cab_core i_cab_core (.*);
    cab_host i_cab_host (.i_ref_clk(i_ref_clk), .i_int_req(o_int_req), .i_delay(host_dly), .o_int_ack(i_int_ack));
    always #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task op(input [3:0] c, input [3:0] s, input [7:0] d, input [15:0] a);
        @(negedge i_ref_clk);
        {i_op_valid, i_op_code, i_op_sel, i_op_data, i_op_addr} = {1'b1, c, s, d, a};
        @(negedge i_ref_clk);
        i_op_valid = 1'b0;
    endtask
    task tmo(input [1:0] c, input [15:0] v);
        @(negedge i_ref_clk);
        {i_tmo_valid, i_tmo_cmd, i_tmo_value} = {1'b1, c, v};
        @(negedge i_ref_clk);
        i_tmo_valid = 1'b0;
    endtask
    function [7:0] pat(input integer kk, input integer ii);
        pat = kk < 2 ? ii[7:0] : (kk < 4 ? 8'h55 : 8'hAA);
    endfunction
    task t_regs;
        for (k = 0; k < 6; k = k + 1) begin
            for (i = 0; i < 16; i = i + 1)
                op(k[0] ? `CAB_OP_WAUX : `CAB_OP_WREG, i[3:0], pat(k, i), 16'h0000);
            for (i = 0; i < 16; i = i + 1) begin
                op(k[0] ? `CAB_OP_RAUX : `CAB_OP_RREG, i[3:0], 8'h00, 16'h0000);
                chk(o_rd_data, pat(k, i));
                chk(o_rd_valid, 16'h0001);
            end
        end
        $display("register test done");
    endtask
    task t_alu(input [7:0] pre, input [3:0] c, input [7:0] opd, input [2:0] f);
        reg [3:0] t;
        t = {1'b1, f};
        op(`CAB_OP_WREG, 4'h0, pre, 16'h0000);
        op(c, 4'h0, opd, 16'h0000);
        for (k = 9; k < 13; k = k + 1) begin
            op(`CAB_OP_SENSE, 4'h0, 8'h00, 16'h0000);
            chk(o_rd_data[2:0], f);
            n = o_pc;
            op(k[3:0], 4'h0, 8'h00, 16'h0ABC);
            chk(o_taken, t[k - 9]);
            chk(o_pc, t[k - 9] ? 16'h0ABC : n + 1);
        end
        $display("alu case done");
    endtask
    task t_link;
        n = o_pc;
        for (k = 1; k < 5; k = k + 1) begin
            op(`CAB_OP_BAL, 4'h0, 8'h00, k << 8);
            chk(o_pc, k < 4 ? k << 8 : 16'h0301);
            chk(o_level, k < 4 ? k : 3);
        end
        for (k = 3; k > 0; k = k - 1) begin
            op(`CAB_OP_RET, 4'h0, 8'h00, 16'h0000);
            chk(o_pc, k > 1 ? ((k - 1) << 8) + 1 : n + 1);
            chk(o_level, k - 1);
        end
        $display("link test done");
    endtask
    task t_mem;
        for (k = 0; k < 8; k = k + 1) begin
            i_mem_we = k < 4;
            n = k[1] ? (k[0] ? 16'h3FFF : 16'h2000) : (k[0] ? 16'h1FFF : 16'h0000);
            op(`CAB_OP_MEM, 4'h0, n[15:8] ^ n[7:0], n[15:0]);
            if (k > 3)
                chk(o_rd_data, n[15:8] ^ n[7:0]);
        end
        i_mem_we = 1'b0;
        $display("memory test done");
    endtask
    task t_tmo;
        for (k = 0; k < 2; k = k + 1) begin
            host_dly = k ? 4'h5 : 4'h0;
            tmo(`CAB_TMO_ENABLE, 16'h000C);
            for (n = 0; o_int_req !== 1'b1 && n < 50; n = n + 1)
                @(negedge i_ref_clk);
            chk(n[15:0], 16'h000C);
            repeat (10) @(negedge i_ref_clk);
            chk(o_int_req, 1'b0);
        end
        for (k = 2; k < 4; k = k + 1) begin
            tmo(`CAB_TMO_ENABLE, 16'h000C);
            repeat (4) @(negedge i_ref_clk);
            tmo(k[1:0], 16'h0000);
            repeat (20) @(negedge i_ref_clk);
            chk(o_int_req, 1'b0);
        end
        $display("timeout test done");
    endtask
    task t_rst;
        op(`CAB_OP_WREG, 4'h7, 8'h3C, 16'h0000);
        op(`CAB_OP_ADD, 4'h7, 8'hC4, 16'h0000);
        op(`CAB_OP_BAL, 4'h0, 8'h00, 16'h0040);
        tmo(`CAB_TMO_ENABLE, 16'h000C);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        chk(o_pc, 16'h0000);
        chk({o_level, o_ind_zero, o_ind_nzero, o_ind_carry}, 16'h0000);
        op(`CAB_OP_RREG, 4'h7, 8'h00, 16'h0000);
        chk(o_rd_data, 8'h00);
        repeat (20) @(negedge i_ref_clk);
        chk(o_int_req, 1'b0);
        $display("reset test done");
    endtask
    initial begin
        repeat (20) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        t_regs;
        t_alu(8'h01, `CAB_OP_ADD, 8'h01, 3'b010);
        t_alu(8'h5A, `CAB_OP_AND, 8'h00, 3'b001);
        t_alu(8'h80, `CAB_OP_ADD, 8'h80, 3'b101);
        t_alu(8'hFF, `CAB_OP_ADD, 8'h02, 3'b110);
        t_alu(8'h05, `CAB_OP_SUB, 8'h05, 3'b101);
        t_link;
        t_mem;
        t_tmo;
        t_rst;
        report_and_stop;
    end
endmodule
